// file: verilog/dsr_pkg.sv
// constants for the pipelined double-cycle-deselect sync sram port
// assumes one 10 MHz clock and an apb register interface
package dsr_pkg;
    // organisation: 512K x 36 default, 1M x 18 alternative
    localparam int ADDR_W_X36   = 19;
    localparam int DATA_W_X36   = 36;
    localparam int ADDR_W_X18   = 20;
    localparam int DATA_W_X18   = 18;
    localparam int LANE_W       = 9;
    localparam int BURST_W      = 2;
    localparam int FIFO_DEPTH   = 8;

    // clock
    localparam int CLOCK_HZ     = 10_000_000;
    localparam int CLOCK_NS     = 1_000_000_000 / CLOCK_HZ;

    // apb register map
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam int CTRL_DRAIN_HOLD    = 0;
    localparam int CTRL_W             = 1;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 1'h0;
    localparam int STAT_ACTIVE        = 0;
    localparam int STAT_SLEEP         = 1;
    localparam int STAT_FIFO_FULL     = 2;
    localparam int STAT_FIFO_EMPTY    = 3;
    localparam int STAT_DRIVE         = 4;
endpackage

// file: verilog/dsr_fifo.sv
// small fifo holding posted array writes
// assumes both sides on the same clock, synchronous reset copy
`timescale 1ns/10ps
module dsr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data,
    // state
    output logic                  full,
    output logic                  empty
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] store_q [DEPTH];
    logic [PW:0]      wr_ptr_q;
    logic [PW:0]      rd_ptr_q;
    wire              push = in_valid & in_ready;
    wire              pop  = out_valid & out_ready;

    assign full      = (wr_ptr_q[PW] != rd_ptr_q[PW]) && (wr_ptr_q[PW-1:0] == rd_ptr_q[PW-1:0]);
    assign empty     = (wr_ptr_q == rd_ptr_q);
    assign in_ready  = ~full;
    assign out_valid = ~empty;
    assign out_data  = store_q[rd_ptr_q[PW-1:0]];

    always_ff @(posedge clk) begin
        if (push) begin
            store_q[wr_ptr_q[PW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
        end
    end

    property p_full_blocks;
        @(posedge clk) disable iff (!rst_n)
        full |-> !in_ready ##1 $stable(wr_ptr_q);
    endproperty
    a_full_blocks: assert property (p_full_blocks) else $error("fifo accepted while full");

    property p_push_counts;
        @(posedge clk) disable iff (!rst_n)
        (push && !pop) |=> (wr_ptr_q - rd_ptr_q) == $past(wr_ptr_q - rd_ptr_q) + 1'b1;
    endproperty
    a_push_counts: assert property (p_push_counts) else $error("fifo level did not grow");
endmodule

// file: verilog/dsr_sram_port.sv
// pipelined double-cycle-deselect sync sram: bus port, burst logic, array
// assumes the bus master runs on CLOCK; OUTPUT_ENABLE_N acts on drivers directly
`timescale 1ns/10ps
// Behaviour
// (RULE1) array is 512K x 36 or 1M x 18
// (RULE2) every synchronous input registered on rising edge
// (RULE3) address and enables load only on strobe
// (RULE4) later burst addresses from two-bit counter
// (RULE5) registered writes complete without further master timing
// (RULE6) writes update chosen byte lanes only
// (RULE7) global write writes every byte lane
// (RULE8) drivers stay on one clock after deselect
// (RULE9) output enable and sleep act unregistered
// (RULE10) burst order interleaved or linear by input
// (RULE11) read burst timing three-one-one-one
// (RULE12) processor strobe wins over controller strobe
// (RULE13) byte write needs enable plus lane selects
// (RULE14) low address bits load the burst counter
// (RULE15) first read clock after deselect undriven
// (RULE16) burst wraps inside its four-word group
module dsr_sram_port #(
    parameter int ADDR_W = dsr_pkg::ADDR_W_X36,
    parameter int DATA_W = dsr_pkg::DATA_W_X36
) (
    // clock and reset
    input  wire logic              CLOCK,
    input  wire logic              ARST_N,
    // synchronous sram bus
    input  wire logic [ADDR_W-1:0] ADDR,
    input  wire logic [DATA_W-1:0] DQ_IN,
    output logic      [DATA_W-1:0] DQ_OUT,
    output logic                   DQ_OE,
    input  wire logic              PROC_ADDR_STROBE_N,
    input  wire logic              CTRL_ADDR_STROBE_N,
    input  wire logic              BURST_ADVANCE_N,
    input  wire logic              GLOBAL_WRITE_N,
    input  wire logic              BYTE_WRITE_ENABLE_N,
    input  wire logic [DATA_W/dsr_pkg::LANE_W-1:0] BYTE_LANE_SELECT_N,
    input  wire logic              CHIP_SELECT_PIPE_N,
    input  wire logic              DEPTH_SELECT_HI,
    input  wire logic              DEPTH_SELECT_LO_N,
    input  wire logic              BURST_LINEAR,
    output logic                   WRITE_READY,
    // asynchronous controls
    input  wire logic              OUTPUT_ENABLE_N,
    input  wire logic              SLEEP_REQUEST,
    // apb slave
    input  wire logic              PSEL,
    input  wire logic              PENABLE,
    input  wire logic              PWRITE,
    input  wire logic [7:0]        PADDR,
    input  wire logic [31:0]       PWDATA,
    output logic      [31:0]       PRDATA,
    output logic                   PREADY,
    output logic                   PSLVERR
);
    localparam int LANES = DATA_W / dsr_pkg::LANE_W;
    localparam int BW    = dsr_pkg::BURST_W;
    localparam int FW    = ADDR_W + DATA_W + LANES;

    function automatic logic [BW-1:0] burst_bits(input logic [BW-1:0] start,
                                                 input logic [BW-1:0] step,
                                                 input logic          linear);
        burst_bits = linear ? start + step : start ^ step;
    endfunction

    // reset release
    logic rst_m_q;
    logic rst_n;
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            rst_m_q <= 1'b0;
            rst_n   <= 1'b0;
        end else begin
            rst_m_q <= 1'b1;
            rst_n   <= rst_m_q;
        end
    end

    // input registers
    logic [ADDR_W-1:0] addr_q;
    logic [DATA_W-1:0] din_q;
    logic              psn_q;
    logic              csn_q;
    logic              advn_q;
    logic              gwn_q;
    logic              bwen_q;
    logic [LANES-1:0]  blsn_q;
    logic              ce1n_q;
    logic              ce2_q;
    logic              ce3n_q;
    logic              lin_q;
    always_ff @(posedge CLOCK) begin
        addr_q <= ADDR;                                                 // RULE2
        din_q  <= DQ_IN;
        psn_q  <= PROC_ADDR_STROBE_N;
        csn_q  <= CTRL_ADDR_STROBE_N;
        advn_q <= BURST_ADVANCE_N;
        gwn_q  <= GLOBAL_WRITE_N;
        bwen_q <= BYTE_WRITE_ENABLE_N;
        blsn_q <= BYTE_LANE_SELECT_N;
        ce1n_q <= CHIP_SELECT_PIPE_N;
        ce2_q  <= DEPTH_SELECT_HI;
        ce3n_q <= DEPTH_SELECT_LO_N;
        lin_q  <= BURST_LINEAR;
    end

    // sleep for access gating, two stages
    logic slp_m_q;
    logic slp_q;
    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            slp_m_q <= 1'b0;
            slp_q   <= 1'b0;
        end else begin
            slp_m_q <= SLEEP_REQUEST;
            slp_q   <= slp_m_q;
        end
    end

    // burst state
    logic [ADDR_W-1:BW] base_q;
    logic [BW-1:0]      start_q;
    logic [BW-1:0]      step_q;
    logic               active_q;

    // access decode
    wire proc_ld  = ~psn_q & ~ce1n_q;                                   // RULE12
    wire ctrl_ld  = ~proc_ld & ~csn_q;                                  // RULE12
    wire ld       = proc_ld | ctrl_ld;
    wire sel_in   = ~ce1n_q & ce2_q & ~ce3n_q;
    wire advance  = ~advn_q;
    wire acc_active = (ld ? sel_in : active_q) & ~slp_q;
    wire [ADDR_W-1:BW] acc_base  = ld ? addr_q[ADDR_W-1:BW] : base_q;  // RULE3
    wire [BW-1:0]      acc_start = ld ? addr_q[BW-1:0] : start_q;       // RULE14
    wire [BW-1:0]      step_inc  = step_q + 2'h1;                       // RULE16
    wire [BW-1:0]      acc_step  = ld ? 2'h0 : (advance ? step_inc : step_q); // RULE4
    wire [ADDR_W-1:0]  acc_addr  = {acc_base, burst_bits(acc_start, acc_step, lin_q)}; // RULE10
    wire [LANES-1:0]   byte_lanes = bwen_q ? {LANES{1'b0}} : ~blsn_q;   // RULE13
    wire [LANES-1:0]   wlanes    = ~gwn_q ? {LANES{1'b1}} : byte_lanes; // RULE7
    wire               acc_write = acc_active & ~proc_ld & (|wlanes);
    wire               acc_read  = acc_active & ~acc_write;

    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            base_q   <= '0;
            start_q  <= 2'h0;
            step_q   <= 2'h0;
            active_q <= 1'b0;
        end else begin
            if (ld) begin
                base_q   <= addr_q[ADDR_W-1:BW];                        // RULE3
                active_q <= sel_in;
            end
            start_q <= acc_start;                                       // RULE14
            step_q  <= acc_step;                                        // RULE4
        end
    end

    // posted writes: address, data, lanes
    logic              drain_hold_q;
    logic              wf_valid;
    logic [FW-1:0]     wf_data;
    logic              wf_full;
    logic              wf_empty;
    logic              wf_ready;
    dsr_fifo #(
        .WIDTH (FW),
        .DEPTH (dsr_pkg::FIFO_DEPTH)
    ) u_wfifo (
        .clk       (CLOCK),
        .rst_n     (rst_n),
        .in_valid  (acc_write),                                         // RULE5
        .in_ready  (wf_ready),
        .in_data   ({acc_addr, din_q, wlanes}),
        .out_valid (wf_valid),
        .out_ready (~drain_hold_q),
        .out_data  (wf_data),
        .full      (wf_full),
        .empty     (wf_empty)
    );
    assign WRITE_READY = wf_ready;

    wire              drain    = wf_valid & ~drain_hold_q;
    wire [ADDR_W-1:0] dr_addr  = wf_data[FW-1:DATA_W+LANES];
    wire [DATA_W-1:0] dr_data  = wf_data[DATA_W+LANES-1:LANES];
    wire [LANES-1:0]  dr_lanes = wf_data[LANES-1:0];

    // array with registered read
    logic [DATA_W-1:0] mem_q [2**ADDR_W];                               // RULE1
    logic [DATA_W-1:0] rd_data_q;
    always_ff @(posedge CLOCK) begin
        for (int i = 0; i < LANES; i++) begin
            if (drain && dr_lanes[i]) begin
                mem_q[dr_addr][i*dsr_pkg::LANE_W +: dsr_pkg::LANE_W] <=
                    dr_data[i*dsr_pkg::LANE_W +: dsr_pkg::LANE_W];     // RULE6
            end
        end
        if (acc_read) begin
            rd_data_q <= mem_q[acc_addr];
        end
    end

    // output pipeline and deselect hold
    logic              rd_valid_q;
    logic              dsel_p1_q;
    logic              drv_q;
    logic              hold_q;
    logic [DATA_W-1:0] dq_q;
    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            rd_valid_q <= 1'b0;
            dsel_p1_q  <= 1'b0;
            drv_q      <= 1'b0;
            hold_q     <= 1'b0;
            dq_q       <= '0;
        end else begin
            rd_valid_q <= acc_read;                                     // RULE11
            dsel_p1_q  <= ld & ~sel_in;
            drv_q      <= rd_valid_q;                                   // RULE11
            hold_q     <= drv_q & dsel_p1_q;                            // RULE8
            if (rd_valid_q) begin
                dq_q <= rd_data_q;
            end
        end
    end

    // first read after deselect keeps the bus quiet
    wire mask_first = ~active_q & acc_read;                             // RULE15
    assign DQ_OUT = dq_q;
    assign DQ_OE  = (drv_q | hold_q) & ~mask_first & ~OUTPUT_ENABLE_N & ~SLEEP_REQUEST; // RULE9

    // apb slave
    wire setup_ph = PSEL & ~PENABLE;
    wire access   = PSEL & PENABLE;
    wire hit_ctrl = (PADDR == dsr_pkg::CTRL_OFS);
    wire hit_stat = (PADDR == dsr_pkg::STATUS_OFS);
    wire [31:0] status_w = {27'h0, drv_q | hold_q, wf_empty, wf_full, slp_q, active_q};
    wire [31:0] rd_mux   = hit_ctrl ? {31'h0, drain_hold_q} : (hit_stat ? status_w : 32'h0);
    logic err_q;
    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            drain_hold_q <= dsr_pkg::CTRL_RESET;
            PRDATA       <= 32'h0;
            err_q        <= 1'b0;
        end else begin
            if (setup_ph) begin
                PRDATA <= PWRITE ? 32'h0 : rd_mux;
                err_q  <= ~(hit_ctrl | hit_stat);
            end
            if (access && PWRITE && hit_ctrl) begin
                drain_hold_q <= PWDATA[dsr_pkg::CTRL_DRAIN_HOLD];
            end
        end
    end
    assign PREADY  = 1'b1;
    assign PSLVERR = access & err_q;

    // checks
    property p_load_only_strobe;
        @(posedge CLOCK) disable iff (!rst_n)
        !ld |=> $stable(base_q);
    endproperty
    a_load_only_strobe: assert property (p_load_only_strobe) else $error("base moved without strobe"); // RULE3

    property p_read_latency;
        @(posedge CLOCK) disable iff (!rst_n)
        acc_read |=> rd_valid_q ##1 drv_q;
    endproperty
    a_read_latency: assert property (p_read_latency) else $error("read data not on time"); // RULE11

    property p_dcd_hold;
        @(posedge CLOCK) disable iff (!rst_n)
        (drv_q && dsel_p1_q) |=> hold_q;
    endproperty
    a_dcd_hold: assert property (p_dcd_hold) else $error("drivers not held after deselect"); // RULE8

    property p_global_write;
        @(posedge CLOCK) disable iff (!rst_n)
        (acc_write && !gwn_q) |-> (wlanes == {LANES{1'b1}});
    endproperty
    a_global_write: assert property (p_global_write) else $error("global write missed a lane"); // RULE7

    property p_proc_wins;
        @(posedge CLOCK) disable iff (!rst_n)
        (!psn_q && !ce1n_q && !csn_q) |-> (proc_ld && !ctrl_ld && !acc_write);
    endproperty
    a_proc_wins: assert property (p_proc_wins) else $error("controller strobe not ignored"); // RULE12

    property p_counter_load;
        @(posedge CLOCK) disable iff (!rst_n)
        ld |=> (start_q == $past(addr_q[BW-1:0])) && (step_q == 2'h0);
    endproperty
    a_counter_load: assert property (p_counter_load) else $error("counter not loaded"); // RULE14

    property p_wrap;
        @(posedge CLOCK) disable iff (!rst_n)
        (!ld && advance && step_q == 2'h3) |=> (step_q == 2'h0) && $stable(base_q);
    endproperty
    a_wrap: assert property (p_wrap) else $error("burst did not wrap"); // RULE16

    property p_first_masked;
        @(posedge CLOCK) disable iff (!rst_n)
        (!active_q && ld && sel_in && !slp_q && (proc_ld || !(|wlanes))) |-> !DQ_OE;
    endproperty
    a_first_masked: assert property (p_first_masked) else $error("bus driven on first read clock"); // RULE15

    property p_byte_needs_enable;
        @(posedge CLOCK) disable iff (!rst_n)
        (acc_write && gwn_q) |-> !bwen_q && (wlanes == ~blsn_q);
    endproperty
    a_byte_needs_enable: assert property (p_byte_needs_enable) else $error("byte write without enable"); // RULE13
endmodule

// file: verification/dsr_bus_master.sv
// bus-master model for the sync sram port: strobes, advance, writes, selects
// assumes tasks are entered just after a rising clk edge
`timescale 1ns/10ps
module dsr_bus_master #(
    parameter int ADDR_W = 6,
    parameter int DATA_W = 36,
    parameter int LANES  = 4
) (
    // clock
    input  wire logic         clk,
    // sram bus
    output logic [ADDR_W-1:0] addr,
    output logic [DATA_W-1:0] wdata,
    output logic              proc_n,
    output logic              ctrl_n,
    output logic              step_n,
    output logic              glob_wr_n,
    output logic              byte_wr_n,
    output logic [LANES-1:0]  lane_n,
    output logic              sel_n,
    output logic              hi_sel,
    output logic              lo_sel_n,
    output logic              linear,
    // cycle launches a read word
    output logic              rd_issue
);
    logic [31:0] seed = 32'hcf6a;
    int          dsel = 0;

    // one bus cycle; unselected cycles rotate which select drops
    task automatic put(input logic p, c, v, g, b, input logic [LANES-1:0] l,
                       input logic s, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d, input logic r);
        proc_n <= p;
        ctrl_n <= c;
        step_n <= v;
        glob_wr_n <= g;
        byte_wr_n <= b;
        lane_n <= l;
        sel_n <= !s && dsel == 0;
        hi_sel <= s || dsel != 1;
        lo_sel_n <= !s && dsel == 2;
        addr <= a;
        wdata <= d;
        rd_issue <= r;
        @(posedge clk);
    endtask

    // released data bus shows the inverse of its last value
    task automatic desel();
        put(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, '1, 1'b0, ADDR_W'($random(seed)), ~wdata, 1'b0);
        dsel = (dsel + 1) % 3;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                      input logic g, b, input logic [LANES-1:0] l);
        put(1'b1, 1'b0, 1'b1, g, b, l, 1'b1, a, d, 1'b0);
        desel();
    endtask

    // address lines wander while the burst advances
    task automatic rd(input logic [ADDR_W-1:0] a, input logic lin, input int n,
                      input logic both);
        linear <= lin;
        put(!both, 1'b0, 1'b1, !both, 1'b1, '1, 1'b1, a, ~wdata, 1'b1);
        for (int i = 1; i < n; i++) begin
            put(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, '1, 1'b0, ADDR_W'($random(seed)), ~wdata, 1'b1);
        end
        desel();
    endtask

    initial begin
        linear = 1'b0;
        put(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, '1, 1'b0, '0, '0, 1'b0);
    end
endmodule

// file: verification/dsr_sram_port_bench.sv
// self-checking bench: apb, write buffer, byte lanes, bursts, output enables
// assumes dsr_pkg, the design files and dsr_bus_master are compiled first
`timescale 1ns/10ps
module dsr_sram_port_bench;
    localparam int AW = 6;
    localparam int DW = 36;
    localparam int LW = dsr_pkg::LANE_W;
    localparam int LN = DW / LW;
    localparam logic [31:0] FULL_B  = 32'h1 << dsr_pkg::STAT_FIFO_FULL;
    localparam logic [31:0] EMPTY_B = 32'h1 << dsr_pkg::STAT_FIFO_EMPTY;
    logic          clock = 1'b0;
    logic          arst_n = 1'b0;
    logic          oe_n = 1'b0;
    logic          sleep = 1'b0;
    logic          psel = 1'b0;
    logic          penable = 1'b0;
    logic          pwrite = 1'b0;
    logic [7:0]    paddr = 8'h00;
    logic [31:0]   pwdata = 32'h0;
    logic [31:0]   prdata;
    logic          pready, pslverr, dq_oe, wr_ready, rd_issue, linear;
    logic          proc_n, ctrl_n, step_n, glob_wr_n, byte_wr_n, sel_n, hi_sel, lo_sel_n;
    logic [LN-1:0] lane_n;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata, dq_out;
    logic [DW-1:0] mem [2**AW];
    logic [DW-1:0] exp_q [$];
    logic [31:0]   seed = 32'hcf6a;
    logic [2:0]    rd_pipe = 3'h0;
    int            n_errors = 0;
    int            cmp_count = 0;
    int            oe_cnt = 0;

    dsr_bus_master #(.ADDR_W(AW), .DATA_W(DW), .LANES(LN)) u (
        .clk(clock), .addr(addr), .wdata(wdata), .proc_n(proc_n), .ctrl_n(ctrl_n),
        .step_n(step_n), .glob_wr_n(glob_wr_n), .byte_wr_n(byte_wr_n), .lane_n(lane_n),
        .sel_n(sel_n), .hi_sel(hi_sel), .lo_sel_n(lo_sel_n), .linear(linear),
        .rd_issue(rd_issue));

    dsr_sram_port #(.ADDR_W(AW), .DATA_W(DW)) dut (
        .CLOCK(clock), .ARST_N(arst_n), .ADDR(addr), .DQ_IN(wdata), .DQ_OUT(dq_out),
        .DQ_OE(dq_oe), .PROC_ADDR_STROBE_N(proc_n), .CTRL_ADDR_STROBE_N(ctrl_n),
        .BURST_ADVANCE_N(step_n), .GLOBAL_WRITE_N(glob_wr_n),
        .BYTE_WRITE_ENABLE_N(byte_wr_n), .BYTE_LANE_SELECT_N(lane_n),
        .CHIP_SELECT_PIPE_N(sel_n), .DEPTH_SELECT_HI(hi_sel), .DEPTH_SELECT_LO_N(lo_sel_n),
        .BURST_LINEAR(linear), .WRITE_READY(wr_ready), .OUTPUT_ENABLE_N(oe_n),
        .SLEEP_REQUEST(sleep), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr));

    task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    function automatic logic [DW-1:0] rnd();
        return DW'({$random(seed), $random(seed)});
    endfunction

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) begin
            @(posedge clock);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask

    task automatic reg_chk(input logic [7:0] a, input logic [31:0] m, x, input logic xe);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        check(r & m, x);
        check(e, xe);
    endtask

    // expected words noted in burst order before the bus model runs
    task automatic burst(input logic [AW-1:0] a, input logic lin, input int n,
                         input logic both);
        logic [1:0] w;
        for (int k = 0; k < n; k++) begin
            w = lin ? a[1:0] + 2'(k) : a[1:0] ^ 2'(k);
            exp_q.push_back(mem[{a[AW-1:2], w}]);
        end
        u.rd(a, lin, n, both);
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // read data taken three edges after its launch
    always @(posedge clock) begin
        if (rd_pipe[2] === 1'b1) begin
            check(dq_out, exp_q.size() > 0 ? exp_q.pop_front() : 'x);
        end
        rd_pipe <= {rd_pipe[1:0], rd_issue};
        oe_cnt <= oe_cnt + int'(dq_oe === 1'b1);
    end

    initial begin
        forever #(dsr_pkg::CLOCK_NS / 2) clock = ~clock;
    end

    initial begin
        #(dsr_pkg::CLOCK_NS * 4000);
        n_errors++;
        test_done();
    end

    initial begin
        logic [31:0]   r;
        logic          e;
        logic [DW-1:0] d;
        logic [AW-1:0] a;
        logic [LN-1:0] l;
        int            c0;
        repeat (3) @(posedge clock);
        arst_n <= 1'b1;
        repeat (3) @(posedge clock);
        reg_chk(dsr_pkg::CTRL_OFS, '1, 32'(dsr_pkg::CTRL_RESET), 1'b0);
        reg_chk(dsr_pkg::STATUS_OFS, '1, EMPTY_B, 1'b0);
        apb(1'b1, 8'h08, '1, r, e);
        check(e, 1'b1);
        reg_chk(8'h08, '1, '0, 1'b1);
        $display("test done: register map");
        for (int i = 0; i < 2**AW; i++) begin
            mem[i] = rnd();
            u.wr(AW'(i), mem[i], 1'b0, 1'b1, '1);
        end
        apb(1'b1, dsr_pkg::CTRL_OFS, 32'h1, r, e);
        reg_chk(dsr_pkg::CTRL_OFS, '1, 32'h1, 1'b0);
        for (int i = 0; i < 8; i++) begin
            mem[i] = rnd();
            u.wr(AW'(i), mem[i], 1'b0, 1'b0, '0);
        end
        repeat (2) @(posedge clock);
        check(wr_ready, 1'b0);
        reg_chk(dsr_pkg::STATUS_OFS, FULL_B | EMPTY_B, FULL_B, 1'b0);
        u.wr(AW'(8), rnd(), 1'b0, 1'b1, '1);
        apb(1'b1, dsr_pkg::CTRL_OFS, 32'h0, r, e);
        repeat (12) @(posedge clock);
        check(wr_ready, 1'b1);
        reg_chk(dsr_pkg::STATUS_OFS, FULL_B | EMPTY_B, EMPTY_B, 1'b0);
        for (int i = 0; i < 9; i++) burst(AW'(i), 1'b0, 1, 1'b0);
        $display("test done: write buffer");
        for (int i = 0; i < 16; i++) begin
            a = AW'($random(seed));
            d = rnd();
            l = LN'($random(seed));
            u.wr(a, d, 1'b1, i[0] & i[1], l);
            for (int j = 0; j < LN; j++) begin
                if (!(i[0] & i[1]) && !l[j]) mem[a][j*LW +: LW] = d[j*LW +: LW];
            end
        end
        repeat (4) @(posedge clock);
        for (int k = 0; k < 32; k++) begin
            a = AW'($random(seed));
            burst({a[AW-1:2], 2'(k >> 1)}, k[0], 4 + k[3], 1'b0);
        end
        $display("test done: byte lanes and bursts");
        burst(a, 1'b0, 1, 1'b1);
        repeat (3) @(posedge clock);
        burst(a, 1'b0, 1, 1'b0);
        repeat (6) @(posedge clock);
        c0 = oe_cnt;
        burst(a, 1'b0, 1, 1'b0);
        repeat (5) @(posedge clock);
        check(oe_cnt - c0, 2);
        fork
            burst(a, 1'b0, 1, 1'b0);
            begin
                repeat (3) @(posedge clock);
                oe_n <= 1'b1;
                #1 check(dq_oe, 1'b0);
                @(posedge clock);
                oe_n <= 1'b0;
                sleep <= 1'b1;
                #1 check(dq_oe, 1'b0);
                @(posedge clock);
                sleep <= 1'b0;
            end
        join
        repeat (6) @(posedge clock);
        check(exp_q.size(), 0);
        $display("test done: strobes and output enables");
        test_done();
    end
endmodule
